// ===== hdl/ubmd_line_ctrl.sv
`timescale 1ns/1ps
module ubmd_line_ctrl
	import ubmd_pkg::*;
(
	input wire logic i_ref_clk, // 125 MHz clock
	input wire logic i_rstn, // synchronous reset, low
	input wire ubmd_cfg_type i_cfg, // host register contents
	input wire logic i_ir_request, // host asks for pulse codec
	input wire logic [3:0] i_gpi, // general-purpose inputs
	input wire logic i_tx_valid, // transmit FIFO holds a word
	input wire logic [7:0] i_tx_data, // word at FIFO head
	input wire logic i_tx_addr, // ninth bit of that word
	output logic o_tx_ready, // word taken this cycle
	output logic o_tx, // serial line out
	output logic o_rts, // transceiver driver enable
	output logic o_ir_codec_enable, // pulse codec may run
	input wire logic i_rx, // serial line in
	output logic o_rx_valid, // store word in receive FIFO
	output ubmd_word_type o_rx_word, // word and its status
	output logic o_address_received_flag, // address word seen
	output logic o_station_address_match_flag // own address seen
);

	ubmd_state_type r;
	ubmd_state_type n;

	logic [8:0] pd;
	logic [7:0] mult;
	logic [9:0] pll_sum;
	logic [9:0] pll_rem;
	logic [20:0] divisor;
	logic [20:0] brg_sum;
	logic [1:0] rate;
	logic four;
	logic [4:0] os_n;
	logic [4:0] mid;
	logic md;
	logic filt;
	logic dir_en;
	logic echo_en;
	logic [3:0] setup_t;
	logic [3:0] hold_t;
	logic [7:0] station_src;
	logic bit_tick;
	logic tx_last;
	logic take;
	logic [4:0] idx;
	logic rx_eval;
	logic rx_val;
	logic noisy;
	logic [3:0] rx_stop;
	ubmd_word_type w;

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	always_comb begin
		unique case (i_cfg.clock_multiplier_predivider[PLL_SEL_HI:PLL_SEL_LO])
			2'h0: mult = PLL_MULT_0;
			2'h1: mult = PLL_MULT_1;
			2'h2: mult = PLL_MULT_2;
			2'h3: mult = PLL_MULT_3;
		endcase
	end

	// A zero predivider would stall the reference, so it acts as one.
	assign pd = (i_cfg.clock_multiplier_predivider[PREDIV_HI:PREDIV_LO] == 6'h00) ? 9'h001 :
		{3'h0, i_cfg.clock_multiplier_predivider[PREDIV_HI:PREDIV_LO]};
	assign divisor = {1'b0, i_cfg.baud_divisor_high_byte, i_cfg.baud_divisor_low_byte,
		i_cfg.baud_generator_settings[DIV_FRAC_HI:DIV_FRAC_LO]};
	assign rate = i_cfg.baud_generator_settings[RATE_HI:RATE_LO];
	assign four = (rate == RATE_4X);
	always_comb begin
		if (four) begin
			os_n = OS_4X;
		end else if (rate == RATE_2X) begin
			os_n = OS_2X;
		end else begin
			os_n = OS_1X;
		end
	end
	assign mid = os_n >> 1;
	assign md = i_cfg.mode_register_two[M2_MDROP];
	assign filt = md & i_cfg.mode_register_two[M2_SPCL];
	assign dir_en = i_cfg.mode_register_one[M1_DIR_EN];
	assign echo_en = i_cfg.mode_register_two[M2_ECHO];
	assign setup_t = i_cfg.direction_setup_hold_delay[DLY_SETUP_HI:DLY_SETUP_LO];
	assign hold_t = i_cfg.direction_setup_hold_delay[DLY_HOLD_HI:DLY_HOLD_LO];
	assign station_src = i_cfg.flow_control_settings[FC_PIN_ADDR] ?
		{i_cfg.second_stop_character[7:4], r.gpi} : i_cfg.second_stop_character;
	assign rx_stop = md ? RX_STOP_9 : RX_STOP_8;

	// ------------------------------------------------------------
	// Transmit handshake
	// ------------------------------------------------------------
	assign bit_tick = r.os_tick & (r.tx_os == os_n - 5'h01);
	assign tx_last = (r.tx_bit == (md ? TX_LAST_9 : TX_LAST_8));
	// A held driver goes straight back to sending, so no fresh setup is spent.
	assign take = i_tx_valid & (
		((r.tx_st == TX_IDLE) & !(dir_en & (setup_t != 4'h0))) |
		((r.tx_st == TX_SETUP) & bit_tick & (r.tx_cnt == 4'h0)) |
		(r.tx_st == TX_HOLD) |
		((r.tx_st == TX_SEND) & bit_tick & tx_last));
	assign o_tx_ready = take;

	// ------------------------------------------------------------
	// Receive sampling
	// ------------------------------------------------------------
	assign idx = (r.rx_os == os_n - 5'h01) ? 5'h00 : r.rx_os + 5'h01;
	assign rx_eval = r.os_tick & (r.rx_st == RX_RUN) &
		(four ? (idx == mid) : (idx == mid + 5'h01));
	assign rx_val = four ? i_rx : ((r.rx_smp[1] & r.rx_smp[0]) | (r.rx_smp[1] & i_rx) |
		(r.rx_smp[0] & i_rx));
	assign noisy = !four & !((r.rx_smp[1] == r.rx_smp[0]) & (r.rx_smp[0] == i_rx));
	always_comb begin
		w.data = md ? r.rx_sh[7:0] : r.rx_sh[8:1];
		w.addr = md & r.rx_sh[8];
		w.noise = (noisy | r.rx_noise) & !four;
		w.frame_err = !rx_val;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.ref_tick = 1'b0;
		n.os_tick = 1'b0;
		n.rx_valid = 1'b0;
		n.addr_flag = 1'b0;
		n.match_flag = 1'b0;
		// Multiplier as a rate accumulator; one reference tick per clock at most.
		pll_sum = {1'b0, r.pll_acc} + {2'h0, mult};
		pll_rem = pll_sum - {1'b0, pd};
		brg_sum = r.brg_acc + BRG_STEP;
		if (pll_sum >= {1'b0, pd}) begin
			n.ref_tick = 1'b1;
			n.pll_acc = (pll_rem >= {1'b0, pd}) ? 9'h000 : pll_rem[8:0];
		end else begin
			n.pll_acc = pll_sum[8:0];
		end
		// The generator counts sixteenths against the full divisor.
		if (r.ref_tick) begin
			if (brg_sum >= divisor) begin
				n.os_tick = 1'b1;
				n.brg_acc = brg_sum - divisor;
			end else begin
				n.brg_acc = brg_sum;
			end
		end
		n.ir_en = i_ir_request & (os_n == OS_1X);
		n.gpi = i_gpi;
		n.station = station_src;

		// Transmitter and direction control.
		if (r.os_tick) begin
			n.tx_os = (r.tx_os == os_n - 5'h01) ? 5'h00 : r.tx_os + 5'h01;
		end
		unique case (r.tx_st)
			TX_IDLE: begin
				if (i_tx_valid & dir_en & (setup_t != 4'h0)) begin
					n.tx_st = TX_SETUP;
					n.tx_cnt = setup_t - 4'h1;
					n.tx_os = 5'h00;
				end
			end
			TX_SETUP: begin
				if (bit_tick & (r.tx_cnt != 4'h0)) begin
					n.tx_cnt = r.tx_cnt - 4'h1;
				end
			end
			TX_SEND: begin
				if (bit_tick) begin
					if (tx_last) begin
						if (dir_en & (hold_t != 4'h0)) begin
							n.tx_st = TX_HOLD;
							n.tx_cnt = hold_t - 4'h1;
						end else begin
							n.tx_st = TX_IDLE;
						end
					end else begin
						n.tx_bit = r.tx_bit + 4'h1;
						n.tx_sh = {1'b1, r.tx_sh[10:1]};
					end
				end
			end
			TX_HOLD: begin
				if (bit_tick) begin
					if (r.tx_cnt == 4'h0) begin
						n.tx_st = TX_IDLE;
					end else begin
						n.tx_cnt = r.tx_cnt - 4'h1;
					end
				end
			end
			default: begin
				n.tx_st = TX_IDLE;
			end
		endcase
		if (take) begin
			n.tx_st = TX_SEND;
			n.tx_bit = 4'h0;
			n.tx_os = 5'h00;
			n.tx_sh = md ? {1'b1, i_tx_addr, i_tx_data, 1'b0} :
				{2'h3, i_tx_data, 1'b0};
		end
		n.tx_line = (n.tx_st == TX_SEND) ? n.tx_sh[0] : 1'b1;
		n.rts = dir_en & (n.tx_st != TX_IDLE);

		// Receiver. Echo marking looks only at the sender, not the driver
		// enable, so the hold time never swallows a genuine reply.
		if (r.os_tick) begin
			unique case (r.rx_st)
				RX_IDLE: begin
					if (!i_rx) begin
						n.rx_st = RX_RUN;
						n.rx_os = 5'h00;
						n.rx_bit = 4'h0;
						n.rx_noise = 1'b0;
						n.rx_echo = (r.tx_st == TX_SEND);
					end
				end
				RX_RUN: begin
					n.rx_os = idx;
					if (idx == 5'h00) begin
						n.rx_bit = r.rx_bit + 4'h1;
					end
					if ((idx == mid - 5'h01) | (idx == mid)) begin
						n.rx_smp = {r.rx_smp[0], i_rx};
					end
				end
				default: begin
					n.rx_st = RX_IDLE;
				end
			endcase
		end
		if (rx_eval) begin
			n.rx_noise = r.rx_noise | noisy;
			if (r.tx_st == TX_SEND) begin
				n.rx_echo = 1'b1;
			end
			if (r.rx_bit == 4'h0) begin
				if (rx_val) begin
					n.rx_st = RX_IDLE;
				end
			end else if (r.rx_bit != rx_stop) begin
				n.rx_sh = {rx_val, r.rx_sh[8:1]};
			end else begin
				n.rx_st = RX_IDLE;
				if (!(echo_en & n.rx_echo)) begin
					if (w.addr) begin
						n.addr_flag = 1'b1;
						if (filt) begin
							n.matched = (w.data == r.station);
							n.match_flag = (w.data == r.station);
						end else begin
							n.rx_valid = 1'b1;
							n.rx_word = w;
						end
					end else if (!filt | r.matched) begin
						n.rx_valid = 1'b1;
						n.rx_word = w;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			r <= '0;
			r.tx_st <= TX_IDLE;
			r.rx_st <= RX_IDLE;
			r.tx_line <= 1'b1;
			r.rx_smp <= 2'h3;
		end else begin
			r <= n;
		end
	end

	assign o_tx = r.tx_line;
	assign o_rts = r.rts;
	assign o_ir_codec_enable = r.ir_en;
	assign o_rx_valid = r.rx_valid;
	assign o_rx_word = r.rx_word;
	assign o_address_received_flag = r.addr_flag;
	assign o_station_address_match_flag = r.match_flag;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_os_from_ref: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		r.os_tick |-> $past(r.ref_tick))
		else $error("baud tick without reference tick");
	chk_ir_rate_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(rate == RATE_4X || rate == RATE_2X) |=> !o_ir_codec_enable)
		else $error("pulse codec on in fast rate");
	chk_rts_on_data: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(r.tx_st == TX_IDLE) && i_tx_valid && dir_en |=> o_rts)
		else $error("driver enable late for waiting data");
	chk_rts_before_tx: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(o_tx) && $past(dir_en) |-> o_rts && ($past(o_rts) || $past(setup_t == 4'h0)))
		else $error("start bit without driver enable");
	chk_rts_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(r.tx_st == TX_HOLD) && $past(r.tx_st == TX_HOLD) |-> o_rts)
		else $error("driver enable dropped during hold");
	chk_echo_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		rx_eval && (r.rx_bit == rx_stop) && echo_en && r.rx_echo |=> !o_rx_valid)
		else $error("echoed word stored");
	chk_filter_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_rx_valid && $past(filt) |-> !o_rx_word.addr)
		else $error("address stored while filtering");
	chk_match_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_station_address_match_flag |-> o_address_received_flag && $past(filt))
		else $error("match flag without address flag");
	chk_noise_4x: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_rx_valid && $past(four) |-> !o_rx_word.noise)
		else $error("noise flagged in quadruple rate");
	chk_addr_mdrop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_address_received_flag |-> $past(md))
		else $error("address flag outside multidrop");
	chk_ready_setup: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		(r.tx_st == TX_SETUP) && !(bit_tick && (r.tx_cnt == 4'h0)) |-> !o_tx_ready)
		else $error("word taken before setup time ended");
	chk_rts_dir_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!dir_en |=> !o_rts)
		else $error("driver enable raised without direction control");
	chk_addr_frame: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		o_rx_valid && o_rx_word.addr |-> $past(md))
		else $error("stored address flag outside multidrop");
	chk_station_pins: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$past(i_rstn) && $past(i_cfg.flow_control_settings[FC_PIN_ADDR]) |->
		(r.station == {$past(i_cfg.second_stop_character[7:4]), $past(r.gpi)}))
		else $error("station address not following pins");
	chk_station_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$past(i_rstn) && !$past(i_cfg.flow_control_settings[FC_PIN_ADDR]) |->
		(r.station == $past(i_cfg.second_stop_character)))
		else $error("station address not the stop character");
	chk_echo_no_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		rx_eval && (r.rx_bit == rx_stop) && echo_en && r.rx_echo |=>
		!o_address_received_flag && !o_station_address_match_flag)
		else $error("echoed word raised a flag");

endmodule // ubmd_line_ctrl

// ===== hdl/ubmd_pkg.sv
// Behaviour
// - Multiply the predivided input clock by 6, 48, 96 or 144 from bits 7:6; the reference is capped at one tick per clock, so 96 and 144 always saturate.
// - Predivide the input clock by 1 to 63 from bits 5:0.
// - Divide the reference by a 16-bit integer plus 4-bit sixteenths divisor.
// - Bit rate is reference times rate multiplier over sixteen times divisor.
// - Integer divisor is held as a high byte and a low byte.
// - Fractional nibble comes from baud settings bits 3:0, step 0.0625.
// - Baud settings bits 5:4 pick standard, double or quadruple line rate.
// - Quadruple rate takes one mid-bit sample instead of three.
// - The pulse codec is off in double and quadruple rate.
// - Multidrop sends eight data bits plus an address flag, no parity.
// - A received word with address flag set raises the address flag.
// - Address filtering needs both special character and multidrop enables.
// - Station address is the stop character, or its upper nibble plus pins.
// - Pin inputs are sampled continuously and update the station address.
// - Data after a matching address is stored, after others discarded.
// - Addresses are not stored while filtering; a match raises its own flag.
// - Direction control drives the driver enable high once data waits.
// - The driver enable rises a programmed setup time before sending.
// - The driver enable stays high a programmed hold time after sending.
// - Echo suppression drops words received while the transmitter sends.
// - Echo suppression and direction control work together independently.
// - Standard and double rate take three samples and flag disagreement.
package ubmd_pkg;
	localparam int PLL_SEL_HI = 7;
	localparam int PLL_SEL_LO = 6;
	localparam int PREDIV_HI = 5;
	localparam int PREDIV_LO = 0;
	localparam logic [7:0] PLL_MULT_0 = 8'h06;
	localparam logic [7:0] PLL_MULT_1 = 8'h30;
	localparam logic [7:0] PLL_MULT_2 = 8'h60;
	localparam logic [7:0] PLL_MULT_3 = 8'h90;
	localparam int DIV_FRAC_HI = 3;
	localparam int DIV_FRAC_LO = 0;
	localparam int RATE_HI = 5;
	localparam int RATE_LO = 4;
	localparam logic [1:0] RATE_2X = 2'h1;
	localparam logic [1:0] RATE_4X = 2'h2;
	localparam logic [4:0] OS_1X = 5'h10;
	localparam logic [4:0] OS_2X = 5'h08;
	localparam logic [4:0] OS_4X = 5'h04;
	localparam int M1_DIR_EN = 4;
	localparam int M2_ECHO = 7;
	localparam int M2_MDROP = 6;
	localparam int M2_SPCL = 4;
	localparam int FC_PIN_ADDR = 2;
	localparam int DLY_SETUP_HI = 7;
	localparam int DLY_SETUP_LO = 4;
	localparam int DLY_HOLD_HI = 3;
	localparam int DLY_HOLD_LO = 0;
	localparam logic [3:0] TX_LAST_8 = 4'h9;
	localparam logic [3:0] TX_LAST_9 = 4'ha;
	localparam logic [3:0] RX_STOP_8 = 4'h9;
	localparam logic [3:0] RX_STOP_9 = 4'ha;
	localparam logic [20:0] BRG_STEP = 21'h000010;

	typedef struct packed {
		logic [7:0] clock_multiplier_predivider;
		logic [7:0] baud_divisor_high_byte;
		logic [7:0] baud_divisor_low_byte;
		logic [7:0] baud_generator_settings;
		logic [7:0] mode_register_one;
		logic [7:0] mode_register_two;
		logic [7:0] flow_control_settings;
		logic [7:0] second_stop_character;
		logic [7:0] direction_setup_hold_delay;
	} ubmd_cfg_type;

	typedef struct packed {
		logic addr;
		logic noise;
		logic frame_err;
		logic [7:0] data;
	} ubmd_word_type;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_SETUP = 4'h2,
		TX_SEND = 4'h4,
		TX_HOLD = 4'h8
	} ubmd_tx_st_type;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h1,
		RX_RUN = 2'h2
	} ubmd_rx_st_type;

	typedef struct packed {
		logic [8:0] pll_acc;
		logic ref_tick;
		logic [20:0] brg_acc;
		logic os_tick;
		ubmd_tx_st_type tx_st;
		logic [4:0] tx_os;
		logic [3:0] tx_bit;
		logic [3:0] tx_cnt;
		logic [10:0] tx_sh;
		logic tx_line;
		logic rts;
		logic ir_en;
		ubmd_rx_st_type rx_st;
		logic [4:0] rx_os;
		logic [3:0] rx_bit;
		logic [8:0] rx_sh;
		logic [1:0] rx_smp;
		logic rx_noise;
		logic rx_echo;
		logic rx_valid;
		ubmd_word_type rx_word;
		logic [3:0] gpi;
		logic [7:0] station;
		logic matched;
		logic addr_flag;
		logic match_flag;
	} ubmd_state_type;
endpackage

// ===== verification/ubmd_xcvr_model.sv
`timescale 1ns/1ps
module ubmd_xcvr_model (
	input wire logic i_drv_en, // driver enable from the device
	input wire logic i_di, // device serial out
	input wire logic i_far_drv_en, // far station drives the bus
	input wire logic i_far_di, // far station serial out
	output logic o_ro // receiver output to the device
);
	// The receiver stays enabled, so the device hears its own echo.
	// Fail-safe bias pulls an undriven bus to idle high.
	always_comb begin
		if (i_drv_en) begin
			o_ro = i_di;
		end else if (i_far_drv_en) begin
			o_ro = i_far_di;
		end else begin
			o_ro = 1'b1;
		end
	end
endmodule // ubmd_xcvr_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ubmd_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	ubmd_cfg_type cfg = '0;
	logic ir_req = 1'b0;
	logic [3:0] gpi = 4'h0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_addr = 1'b0;
	logic far_drv_en = 1'b0;
	logic far_di = 1'b1;
	logic tx_ready, tx, rts, ir_en, rx, rx_valid, addr_flag, match_flag;
	ubmd_word_type rx_word, last_word;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	int n_rx = 0;
	int n_addr = 0;
	int n_match = 0;
	localparam logic [31:0] RTAB [8] = '{32'h0c000100, 32'h0c000110, 32'h0c000120,
		32'h0c000130, 32'h0c000200, 32'h0c000108, 32'h0c010100, 32'h7f000100};
	localparam int RLEN [8] = '{32, 16, 8, 32, 64, 48, 8224, 21};
	localparam logic [8:0] FW [10] = '{9'h13c, 9'h011, 9'h155, 9'h022, 9'h157, 9'h033,
		9'h157, 9'h044, 9'h158, 9'h066};
	localparam logic [2:0] FE [10] = '{3'h3, 3'h4, 3'h2, 3'h0, 3'h3, 3'h4, 3'h2, 3'h0,
		3'h3, 3'h4};

	always #4 i_ref_clk = ~i_ref_clk;

	ubmd_line_ctrl u_ubmd_line_ctrl (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cfg(cfg),
		.i_ir_request(ir_req), .i_gpi(gpi), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.i_tx_addr(tx_addr), .o_tx_ready(tx_ready), .o_tx(tx), .o_rts(rts),
		.o_ir_codec_enable(ir_en), .i_rx(rx), .o_rx_valid(rx_valid), .o_rx_word(rx_word),
		.o_address_received_flag(addr_flag), .o_station_address_match_flag(match_flag));

	ubmd_xcvr_model u_ubmd_xcvr_model (.i_drv_en(rts), .i_di(tx), .i_far_drv_en(far_drv_en),
		.i_far_di(far_di), .o_ro(rx));

	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (rx_valid === 1'b1) begin
			n_rx <= n_rx + 1;
			last_word <= rx_word;
		end
		if (addr_flag === 1'b1) n_addr <= n_addr + 1;
		if (match_flag === 1'b1) n_match <= n_match + 1;
		if (cycles == 40000) begin
			mismatches++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Stimulus and checking tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Tick accumulators jitter by a clock or two, so timing gets a small window.
	task automatic near(input string what, input int exp, input int got);
		checks++;
		if (got > exp + 3 || got < exp - 3) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic do_reset();
		@(negedge i_ref_clk);
		i_rstn = 1'b0;
		repeat (2) @(negedge i_ref_clk);
		i_rstn = 1'b1;
	endtask

	// Holds the word until the take edge has passed.
	task automatic send(input logic [8:0] w);
		int k;
		k = 0;
		@(negedge i_ref_clk);
		tx_valid = 1'b1;
		{tx_addr, tx_data} = w;
		while (k < 20000) begin
			#1;
			if (tx_ready === 1'b1) break;
			@(negedge i_ref_clk);
			k++;
		end
		if (k >= 20000) mismatches++;
		@(negedge i_ref_clk);
		tx_valid = 1'b0;
	endtask

	task automatic low_len(output int n);
		int k;
		k = 0;
		n = 0;
		while (tx !== 1'b0 && k < 50) begin
			@(negedge i_ref_clk);
			k++;
		end
		while (tx === 1'b0 && n < 20000) begin
			@(negedge i_ref_clk);
			n++;
		end
	endtask

	task automatic dir_frame(output int su, output int tot, output logic [10:0] bits);
		su = 0;
		tot = 0;
		bits = '0;
		while (rts !== 1'b1 && tot < 100) begin
			@(negedge i_ref_clk);
			tot++;
		end
		while (tx !== 1'b0 && su < 200) begin
			@(negedge i_ref_clk);
			su++;
		end
		tot = 0;
		while (rts === 1'b1 && tot < 1000) begin
			if (tot % 32 == 16 && tot < 352) bits[tot / 32] = tx;
			@(negedge i_ref_clk);
			tot++;
		end
	endtask

	// Far station frame; bit gb is inverted for two clocks from offset ga.
	task automatic far_send(input logic [8:0] w, input int nb, input int bt, input int gb,
		input int ga);
		logic [11:0] f;
		f = (nb == 9) ? {2'b11, w, 1'b0} : {3'b111, w[7:0], 1'b0};
		for (int b = 0; b < nb + 2; b++) begin
			for (int c = 0; c < bt; c++) begin
				@(negedge i_ref_clk);
				far_drv_en = 1'b1;
				far_di = (b == gb && (c == ga || c == ga + 1)) ? ~f[b] : f[b];
			end
		end
		@(negedge i_ref_clk);
		far_drv_en = 1'b0;
		repeat (2 * bt) @(negedge i_ref_clk);
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		int n, su, tot, r0, a0, m0;
		logic [10:0] bits;
		logic [1:0] rc;
		repeat (16) @(negedge i_ref_clk);
		i_rstn = 1'b1;
		for (int i = 0; i < 8; i++) begin
			cfg = {RTAB[i], 40'h0};
			ir_req = 1'b1;
			do_reset();
			send(9'h055);
			low_len(n);
			near("bit time", RLEN[i], n);
			rc = RTAB[i][5:4];
			chk("codec enable", 32'(rc != 2'h1 && rc != 2'h2), 32'(ir_en));
		end
		for (int e = 0; e < 2; e++) begin
			cfg = {40'h0c00010010, e[0], 7'h40, 24'h000023};
			do_reset();
			r0 = n_rx;
			a0 = n_addr;
			fork
				send(9'h1a5);
				dir_frame(su, tot, bits);
			join
			near("setup", 64, su);
			near("hold", 448, tot);
			chk("frame bits", 32'h74a, 32'(bits));
			chk("echo stored", 32'(1 - e), 32'(n_rx - r0));
			chk("echo addr flag", 32'(1 - e), 32'(n_addr - a0));
			if (e == 0) chk("echo word", 32'h4a5, 32'(last_word));
		end
		cfg = 72'h0c_00_01_00_00_50_00_3c_00;
		do_reset();
		for (int i = 0; i < 10; i++) begin
			@(negedge i_ref_clk);
			cfg.flow_control_settings = (i >= 4) ? 8'h04 : 8'h00;
			cfg.second_stop_character = (i >= 4) ? 8'h50 : 8'h3c;
			gpi = (i < 6) ? 4'h7 : 4'h8;
			r0 = n_rx;
			a0 = n_addr;
			m0 = n_match;
			far_send(FW[i], 9, 32, 99, 0);
			chk("stored", 32'(FE[i][2]), 32'(n_rx - r0));
			chk("addr flag", 32'(FE[i][1]), 32'(n_addr - a0));
			chk("match flag", 32'(FE[i][0]), 32'(n_match - m0));
			if (FE[i][2]) chk("data", 32'(FW[i]), 32'(last_word));
		end
		cfg = 72'h0c_00_01_00_00_00_00_00_00;
		for (int q = 0; q < 2; q++) begin
			@(negedge i_ref_clk);
			cfg.baud_generator_settings = (q == 1) ? 8'h20 : 8'h00;
			r0 = n_rx;
			far_send(9'h0c3, 8, (q == 1) ? 8 : 32, 3, (q == 1) ? 2 : 16);
			chk("noise stored", 32'h1, 32'(n_rx - r0));
			chk("noise word", (q == 1) ? 32'h0c3 : 32'h2c3, 32'(last_word));
		end
		wrap_up();
	end
endmodule // tb_top
